// ==== logic/wac_defs.svh ====
// constants of the waveform acquisition controller
`ifndef WAC_DEFS_SVH
`define WAC_DEFS_SVH
`define WAC_CLK_MHZ       100
`define WAC_REC_PTS       12'd2500
`define WAC_PK_INTV       12'd1250
`define WAC_GAP_PTS       12'd250
`define WAC_RATE_LO_MSPS  500
`define WAC_RATE_HI_MSPS  1000
// least spacing of accepted samples, never under one cycle
`define WAC_GAP_LO ((`WAC_CLK_MHZ + `WAC_RATE_LO_MSPS - 1) / `WAC_RATE_LO_MSPS)
`define WAC_GAP_HI ((`WAC_CLK_MHZ + `WAC_RATE_HI_MSPS - 1) / `WAC_RATE_HI_MSPS)
// timebase codes in 1-2.5-5 steps, code 0 is 5 ns/div
`define WAC_TB_INTERP_MAX 5'h04
`define WAC_TB_PK_SMP_MAX 5'h11
`define WAC_TB_ROLL_MIN   5'h16
// register offsets
`define WAC_REG_CTRL      4'h0
`define WAC_REG_TBASE     4'h1
`define WAC_REG_DECIM     4'h2
`define WAC_REG_INTERP    4'h3
`define WAC_REG_CMD       4'h4
`define WAC_REG_STAT      4'h5
`define WAC_REG_POS       4'h6
// field positions
`define WAC_CTRL_MODE     1:0
`define WAC_CTRL_AVG      3:2
`define WAC_CTRL_AUTO     4
`define WAC_CMD_RUN       0
`define WAC_CMD_ONE       1
// reset values
`define WAC_CTRL_RST      16'h0000
`define WAC_TBASE_RST     5'h00
`define WAC_DECIM_RST     12'h001
`define WAC_INTERP_RST    2'h0
`endif

// ==== logic/wac_pkg.sv ====
// types of the waveform acquisition controller
package wac_pkg;
  typedef enum logic [1:0] {WAC_SAMPLE, WAC_PEAK, WAC_AVG} wac_mode_t;
  typedef enum {ST_HALT, ST_ARMED, ST_FILL} wac_state_t;
  typedef logic [7:0]  wac_smp_t;
  typedef logic [11:0] wac_idx_t;
endpackage : wac_pkg

// ==== logic/wac_pt_if.sv ====
// point stream between the acquisition stages
`timescale 1ns/1ps
`default_nettype none
interface wac_pt_if;
  import wac_pkg::*;
  logic     valid;
  wac_smp_t hi;
  wac_smp_t lo;
  modport src (output valid, hi, lo);
  modport dst (input valid, hi, lo);
endinterface : wac_pt_if
`default_nettype wire

// ==== logic/wac_reduce.sv ====
// interval reducer: decimation, min/max and interpolation
`timescale 1ns/1ps
`default_nettype none
module wac_reduce
  import wac_pkg::*;
(
  // clock and reset
  input  wire logic       sys_clk,
  input  wire logic       nrst,
  // control
  input  wire logic       restart,
  input  wire logic       peak,
  input  wire logic       interp_on,
  input  wire logic [1:0] ishift,
  input  wire logic [11:0] decim,
  // samples
  input  wire logic       accept,
  input  wire wac_smp_t   smp,
  output logic            ready,
  // points
  wac_pt_if.src           pt
);
  `include "wac_defs.svh"

  // linear step between two real samples
  function automatic wac_smp_t lerp(wac_smp_t a, wac_smp_t b,
                                    logic [3:0] k, logic [1:0] s);
    logic signed [9:0]  d;
    logic signed [14:0] p;
    d = signed'({2'b00, b}) - signed'({2'b00, a});
    p = d * signed'({1'b0, k});
    lerp = wac_smp_t'(10'({2'b00, a}) + 10'(p >>> s));
  endfunction : lerp

  logic [11:0] cnt;
  wac_smp_t    hi, lo, prv, cur;
  logic        busy;
  logic [3:0]  k;

  ////////////////////////////////////////////////////////////////////
  // interval decode; a zero divisor counts as one
  wire       first_s = (cnt == 12'h000);
  wire       last_s  = ((cnt + 12'h001) >= decim);
  wire [3:0] kmax    = 4'(1 << ishift);
  wire       kend    = (k == kmax);
  wire wac_smp_t next_hi = (first_s || (peak && smp > hi)) ? smp : hi;
  wire wac_smp_t next_lo = (first_s || (peak && smp < lo)) ? smp : lo;
  wire wac_smp_t ival    = lerp(prv, cur, k, ishift);

  // stall the source while a burst of filler points goes out
  assign ready = !busy;

  // interval and burst state
  always_ff @(posedge sys_clk) begin
    if (!nrst || restart) begin
      cnt  <= 12'h000;
      hi   <= 8'h00;
      lo   <= 8'h00;
      prv  <= 8'h00;
      cur  <= 8'h00;
      busy <= 1'b0;
      k    <= 4'h0;
    end else if (interp_on) begin
      if (accept) begin
        prv  <= cur;
        cur  <= smp;
        busy <= 1'b1;
        k    <= 4'h1;
      end else if (busy) begin
        k    <= k + 4'h1;
        busy <= !kend;
      end
    end else if (accept) begin
      cnt <= last_s ? 12'h000 : cnt + 12'h001;
      hi  <= next_hi;
      lo  <= next_lo;
    end
  end

  // registered point output
  always_ff @(posedge sys_clk) begin
    if (!nrst || restart) begin
      pt.valid <= 1'b0;
      pt.hi    <= 8'h00;
      pt.lo    <= 8'h00;
    end else begin
      pt.valid <= interp_on ? busy : (accept && last_s);
      pt.hi    <= interp_on ? ival : next_hi;
      pt.lo    <= interp_on ? ival : next_lo;
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst || restart);
  a_one_per_intv: assert property (!interp_on && accept && !last_s
    |=> !pt.valid) else $error("point left before interval end");
  a_peak_tracks: assert property (peak && !interp_on && accept &&
    !first_s |=> hi >= $past(smp) && lo <= $past(smp))
    else $error("min/max missed a sample");
endmodule : wac_reduce
`default_nettype wire

// ==== logic/wac_avg.sv ====
// record averager over successive records
`timescale 1ns/1ps
`default_nettype none
module wac_avg
  import wac_pkg::*;
(
  // clock and reset
  input  wire logic       sys_clk,
  input  wire logic       nrst,
  // control
  input  wire logic       en,
  input  wire logic       first,
  input  wire logic [2:0] ashift,
  input  wire wac_idx_t   idx,
  // points in and out
  wac_pt_if.dst           pin,
  wac_pt_if.src           pout
);
  `include "wac_defs.svh"

  // sums of up to 128 eight-bit records, no reset needed
  logic [14:0] acc [0:2499];

  wire [14:0] sum = first ? {7'h00, pin.hi} : acc[idx] + {7'h00, pin.hi};
  wire [14:0] avg = sum >> ashift;

  always_ff @(posedge sys_clk) begin
    if (pin.valid && en) begin
      acc[idx] <= sum;
    end
  end

  // one cycle of latency in every mode
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      pout.valid <= 1'b0;
      pout.hi    <= 8'h00;
      pout.lo    <= 8'h00;
    end else begin
      pout.valid <= pin.valid;
      pout.hi    <= en ? avg[7:0] : pin.hi;
      pout.lo    <= en ? avg[7:0] : pin.lo;
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  a_avg_first: assert property (en && pin.valid && first
    |=> pout.hi == 8'(15'($past(pin.hi)) >> $past(ashift)))
    else $error("first record not loaded");
endmodule : wac_avg
`default_nettype wire

// ==== logic/wac_acq.sv ====
// waveform acquisition controller top
//
// How it works
// - sample mode builds 2500-point records over the timebase.
// - sample mode keeps one sample per interval, drops the rest.
// - accepted sample rate capped at 500 MS/s or 1 GS/s.
// - at 100 ns/div or faster, points interpolated to fill 2500.
// - min/max mode stores highest and lowest of 1250 intervals.
// - min/max examines every sample so 10 ns pulses show.
// - min/max at 2.5 ms/div or faster silently runs as sample.
// - averaging mode averages 4, 16, 64 or 128 sample records.
// - run/halt command toggles continuous acquisition, re-arming.
// - one-shot arms, waits for trigger, completes record, halts.
// - one-shot ends after one record, or after full average.
// - rolling display at 100 ms/div or slower with free trigger.
// - rolling writes left to right, one division blank ahead.
// - running updates display; halted freezes the record.
//
// Added by the designer: the address map and the strobed register port.
`timescale 1ns/1ps
`default_nettype none
module wac_acq
  import wac_pkg::*;
#(
  parameter bit HI_BW = 1'b0
)(
  // clock and reset
  input  wire logic        sys_clk,
  input  wire logic        nrst,
  // converter and trigger
  input  wire logic        adc_valid,
  input  wire wac_smp_t    adc_data,
  input  wire logic        trig_hit,
  // register port
  input  wire logic [3:0]  reg_addr,
  input  wire logic [15:0] reg_wdata,
  input  wire logic        reg_we,
  input  wire logic        reg_re,
  output logic [15:0]      reg_rdata,
  // display path
  output logic             disp_wr,
  output wac_idx_t         disp_addr,
  output wac_smp_t         disp_hi,
  output wac_smp_t         disp_lo,
  output logic             disp_gap_wr,
  output wac_idx_t         disp_gap_addr,
  // status
  output logic             acq_running,
  output logic             rec_done
);
  `include "wac_defs.svh"

  localparam int GAP = HI_BW ? `WAC_GAP_HI : `WAC_GAP_LO;

  // wrap an index into the record
  function automatic wac_idx_t wrap_add(wac_idx_t a, wac_idx_t b);
    logic [12:0] s;
    s = {1'b0, a} + {1'b0, b};
    wrap_add = (s >= {1'b0, `WAC_REC_PTS}) ?
               12'(s - {1'b0, `WAC_REC_PTS}) : s[11:0];
  endfunction : wrap_add

  ////////////////////////////////////////////////////////////////////
  // configuration registers
  logic [15:0] ctrl;
  logic [4:0]  tbase;
  logic [11:0] decim;
  logic [1:0]  ishift;

  wac_state_t  st;
  logic        run;
  logic        one;
  wac_idx_t    idx;
  logic [6:0]  avg_k;
  logic [3:0]  gap_cnt;
  logic        red_ready;

  // register decode
  wire wr_ctrl  = reg_we && reg_addr == `WAC_REG_CTRL;
  wire wr_tb    = reg_we && reg_addr == `WAC_REG_TBASE;
  wire wr_dec   = reg_we && reg_addr == `WAC_REG_DECIM;
  wire wr_int   = reg_we && reg_addr == `WAC_REG_INTERP;
  wire wr_cmd   = reg_we && reg_addr == `WAC_REG_CMD;
  wire cmd_run  = wr_cmd && reg_wdata[`WAC_CMD_RUN];
  wire cmd_one  = wr_cmd && reg_wdata[`WAC_CMD_ONE];
  wire cfg_chg  = wr_ctrl || wr_tb || wr_dec || wr_int;

  // mode decode; the spare code falls back to sample
  wire [1:0] mode_f  = ctrl[`WAC_CTRL_MODE];
  wire       avg_sel = (mode_f == 2'(WAC_AVG));
  wire       eff_pk  = (mode_f == 2'(WAC_PEAK)) &&
                       (tbase > `WAC_TB_PK_SMP_MAX);
  wire       interp  = (tbase <= `WAC_TB_INTERP_MAX);
  wire       roll    = (tbase >= `WAC_TB_ROLL_MIN) &&
                       ctrl[`WAC_CTRL_AUTO];
  wire wac_idx_t rec_len = eff_pk ? `WAC_PK_INTV : `WAC_REC_PTS;
  wire [1:0] asel    = ctrl[`WAC_CTRL_AVG];
  wire [2:0] ashift  = (asel == 2'h3) ? 3'd7 : {asel, 1'b0} + 3'd2;
  wire [6:0] avg_n1  = 7'((8'h01 << ashift) - 8'h01);
  wire       avg_last = !avg_sel || (avg_k == avg_n1);

  // config writes
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      ctrl   <= `WAC_CTRL_RST;
      tbase  <= `WAC_TBASE_RST;
      decim  <= `WAC_DECIM_RST;
      ishift <= `WAC_INTERP_RST;
    end else begin
      if (wr_ctrl) ctrl <= reg_wdata;
      if (wr_tb) tbase <= reg_wdata[4:0];
      if (wr_dec) decim <= reg_wdata[11:0];
      if (wr_int) ishift <= reg_wdata[1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////
  // sample intake; only a filling record takes samples
  wire fill   = (st == ST_FILL);
  wire accept = adc_valid && red_ready && fill && gap_cnt == 4'h0;
  // restart the reducer whenever a record (re)starts
  wire arm_go = (st == ST_ARMED) && (trig_hit || roll);
  wire red_rst = arm_go || cfg_chg || cmd_one;

  always_ff @(posedge sys_clk) begin
    if (!nrst) gap_cnt <= 4'h0;
    else if (accept) gap_cnt <= 4'(GAP - 1);
    else if (gap_cnt != 4'h0) gap_cnt <= gap_cnt - 4'h1;
  end

  // cycles since the last taken sample, saturating, for the rate check
  logic [3:0] since_acc;
  always_ff @(posedge sys_clk) begin
    if (!nrst) since_acc <= 4'hF;
    else if (accept) since_acc <= 4'h0;
    else if (since_acc != 4'hF) since_acc <= since_acc + 4'h1;
  end

  wac_pt_if red_pt ();
  wac_pt_if avg_pt ();

  wac_reduce u_reduce (
    .sys_clk   (sys_clk),
    .nrst      (nrst),
    .restart   (red_rst),
    .peak      (eff_pk),
    .interp_on (interp),
    .ishift    (ishift),
    .decim     (decim),
    .accept    (accept),
    .smp       (adc_data),
    .ready     (red_ready),
    .pt        (red_pt.src)
  );

  // points count only while filling, leftovers are dropped
  wire pt_in   = red_pt.valid && fill;
  wire pt_last = pt_in && (idx == rec_len - 12'h001);
  wire avg_on  = avg_sel && !eff_pk;

  wac_pt_if gate_pt ();
  assign gate_pt.valid = pt_in;
  assign gate_pt.hi    = red_pt.hi;
  assign gate_pt.lo    = red_pt.lo;

  wac_avg u_avg (
    .sys_clk (sys_clk),
    .nrst    (nrst),
    .en      (avg_on),
    .first   (avg_k == 7'h00),
    .ashift  (ashift),
    .idx     (idx),
    .pin     (gate_pt.dst),
    .pout    (avg_pt.src)
  );

  ////////////////////////////////////////////////////////////////////
  // run toggles
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      st    <= ST_HALT;
      run   <= 1'b0;
      one   <= 1'b0;
      idx   <= 12'h000;
      avg_k <= 7'h00;
    end else if (cmd_one) begin
      st    <= ST_ARMED;
      run   <= 1'b0;
      one   <= 1'b1;
      idx   <= 12'h000;
      avg_k <= 7'h00;
    end else if (cmd_run) begin
      st    <= run ? ST_HALT : ST_ARMED;
      run   <= !run;
      one   <= 1'b0;
      idx   <= 12'h000;
    end else if (cfg_chg) begin
      idx   <= 12'h000;
      avg_k <= 7'h00;
      if (st == ST_FILL) st <= ST_ARMED;
    end else begin
      unique case (st)
        ST_HALT: ;
        ST_ARMED: if (arm_go) st <= ST_FILL;
        ST_FILL: begin
          if (pt_last && roll && run) begin
            idx <= 12'h000;
          end else if (pt_last) begin
            idx   <= 12'h000;
            avg_k <= avg_last ? 7'h00 : avg_k + 7'h01;
            st    <= (one && avg_last) ? ST_HALT : ST_ARMED;
            if (one && avg_last) one <= 1'b0;
          end else if (pt_in) begin
            idx <= idx + 12'h001;
          end
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////
  // display writes follow the averager by one cycle
  wac_idx_t out_idx;
  logic     out_show;
  logic     out_roll;
  logic     out_end;

  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      out_idx  <= 12'h000;
      out_show <= 1'b0;
      out_roll <= 1'b0;
      out_end  <= 1'b0;
    end else begin
      out_idx  <= idx;
      out_show <= pt_in && avg_last;
      out_roll <= roll;
      out_end  <= pt_last;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      disp_wr       <= 1'b0;
      disp_addr     <= 12'h000;
      disp_hi       <= 8'h00;
      disp_lo       <= 8'h00;
      disp_gap_wr   <= 1'b0;
      disp_gap_addr <= 12'h000;
      rec_done      <= 1'b0;
    end else begin
      disp_wr       <= avg_pt.valid && out_show;
      disp_addr     <= out_idx;
      disp_hi       <= avg_pt.hi;
      disp_lo       <= avg_pt.lo;
      disp_gap_wr   <= avg_pt.valid && out_show && out_roll;
      disp_gap_addr <= wrap_add(out_idx, `WAC_GAP_PTS);
      rec_done      <= avg_pt.valid && out_end;
    end
  end

  assign acq_running = run;

  // register read, one cycle later
  always_ff @(posedge sys_clk) begin
    if (!nrst) reg_rdata <= 16'h0000;
    else if (!reg_re) reg_rdata <= 16'h0000;
    else begin
      unique case (reg_addr)
        `WAC_REG_CTRL:   reg_rdata <= ctrl;
        `WAC_REG_TBASE:  reg_rdata <= {11'h000, tbase};
        `WAC_REG_DECIM:  reg_rdata <= {4'h0, decim};
        `WAC_REG_INTERP: reg_rdata <= {14'h0000, ishift};
        `WAC_REG_STAT:   reg_rdata <= {avg_k, 3'h0, eff_pk, roll,
                                       fill, st == ST_ARMED, one, run};
        `WAC_REG_POS:    reg_rdata <= {4'h0, idx};
        default:         reg_rdata <= 16'h0000;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);

  a_rec_wrap: assert property (pt_last && !cfg_chg && !wr_cmd
    |=> idx == 12'h000) else $error("record did not wrap at length");
  a_rate_gap: assert property (accept
    |-> int'(since_acc) >= GAP - 1) else $error("samples too close");
  a_pk_len: assert property (eff_pk && pt_in && !pt_last && !cfg_chg
    && !wr_cmd |=> idx == $past(idx) + 12'h001)
    else $error("min/max index skipped");
  a_pk_forced: assert property (tbase <= `WAC_TB_PK_SMP_MAX
    |-> !eff_pk) else $error("min/max kept at fast timebase");
  a_run_toggle: assert property (cmd_run && !cmd_one
    |=> run == !$past(run)) else $error("run did not toggle");
  a_one_halts: assert property (one && pt_last && avg_last && !reg_we
    |=> st == ST_HALT ##3 !fill) else $error("one-shot did not halt");
  a_avg_more: assert property (one && pt_last && !avg_last && !reg_we
    |=> st == ST_ARMED && one) else $error("one-shot ended early");
  a_roll_arm: assert property (roll && st == ST_ARMED && !reg_we
    |=> fill) else $error("rolling waited for trigger");
  a_gap_ahead: assert property (disp_gap_wr
    |-> disp_gap_addr == wrap_add(disp_addr, `WAC_GAP_PTS))
    else $error("blank gap misplaced");
  a_halt_frozen: assert property (st == ST_HALT && !reg_we
    |=> ##2 !disp_wr) else $error("display written while halted");
  a_cfg_restart: assert property (cfg_chg && !wr_cmd
    |=> avg_k == 7'h00 && idx == 12'h000) else $error("no restart");

  c_one_done:  cover property (one ##1 st == ST_HALT);
  c_avg_full:  cover property (avg_sel && pt_last && avg_last);
  c_roll_gap:  cover property (disp_gap_wr);
  c_pk_record: cover property (eff_pk && rec_done);
endmodule : wac_acq
`default_nettype wire

// ==== sim/wac_src_model.sv ====
// converter channel and trigger detector model
`timescale 1ns/1ps
`default_nettype none
module wac_src_model
  import wac_pkg::*;
(
  // clock
  input  wire logic     sys_clk,
  // bench requests
  input  wire logic     feed,
  input  wire wac_smp_t feed_data,
  input  wire logic     fire,
  // converter and trigger
  output logic          adc_valid,
  output wac_smp_t      adc_data,
  output logic          trig_hit
);
  ////////////////////////////////////////////////////////////////////////////
  // quiet lines at time zero, then one update per rising edge
  // idle data inverts each cycle so a stale sample never looks good
  initial begin
    adc_valid = 1'b0;
    adc_data  = 8'h00;
    trig_hit  = 1'b0;
    forever begin
      @(posedge sys_clk);
      adc_valid <= feed;
      adc_data  <= feed ? feed_data : ~adc_data;
      trig_hit  <= fire;
    end
  end
endmodule : wac_src_model
`default_nettype wire

// ==== sim/test_waveform_acquisition_control.sv ====
// self-checking bench of the acquisition controller
`timescale 1ns/1ps
`default_nettype none
module test_waveform_acquisition_control
  import wac_pkg::*;
;
  logic        sys_clk = 1'b0;
  logic        nrst = 1'b0;
  logic        feed = 1'b0;
  logic        fire = 1'b0;
  logic        reg_we = 1'b0;
  logic        reg_re = 1'b0;
  logic [3:0]  reg_addr = 4'h0;
  logic [15:0] reg_wdata = 16'h0000;
  wac_smp_t    feed_data = 8'h00;
  logic [31:0] seed = 32'h2DA3;
  logic        adc_valid, trig_hit, disp_wr, disp_gap_wr;
  logic        acq_running, rec_done;
  wac_smp_t    adc_data, disp_hi, disp_lo;
  wac_idx_t    disp_addr, disp_gap_addr;
  logic [15:0] reg_rdata, rv;
  int          n_fail = 0, checks_done = 0, n_rec = 0, nr = 0;
  int          loose = 0, n_loose = 0, roll = 0, slow = 0;
  int          acc[2500];
  int          q_a[$], q_h[$], q_l[$];

  ////////////////////////////////////////////////////////////////////////////
  // clock and parts
  always #5 sys_clk = ~sys_clk;
  wac_src_model u_wac_src_model (.sys_clk, .feed, .feed_data, .fire,
    .adc_valid, .adc_data, .trig_hit);
  wac_acq #(.HI_BW(1'b1)) u_wac_acq (.sys_clk, .nrst, .adc_valid,
    .adc_data, .trig_hit, .reg_addr, .reg_wdata, .reg_we, .reg_re,
    .reg_rdata, .disp_wr, .disp_addr, .disp_hi, .disp_lo, .disp_gap_wr,
    .disp_gap_addr, .acq_running, .rec_done);

  ////////////////////////////////////////////////////////////////////////////
  function automatic int rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return int'(seed);
  endfunction : rnd

  task automatic test_done();
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : test_done

  task automatic chk(input logic [15:0] got, exp, input string m);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask : chk

  // display point against the head of the expected queue
  task automatic chk_pt();
    int a;
    a = 0;
    if (loose) begin
      chk(16'(disp_addr), 16'(n_loose), "fill index");
      n_loose++;
    end else if (q_a.size() == 0) begin
      chk(16'(disp_wr), 16'h0000, "stray point");
    end else begin
      a = q_a.pop_front();
      chk(16'(disp_addr), 16'(a), "point index");
      chk(16'(disp_hi), 16'(q_h.pop_front()), "point high");
      chk(16'(disp_lo), 16'(q_l.pop_front()), "point low");
    end
    chk(16'(disp_gap_wr), 16'(roll), "blank strobe");
    if (roll)
      chk(16'(disp_gap_addr), 16'((a + 250) % 2500), "blank idx");
  endtask : chk_pt

  // every display write and record end is judged where it happens
  always @(posedge sys_clk) begin
    if (nrst && rec_done === 1'b1)
      n_rec++;
    if (nrst && disp_wr !== 1'b0)
      chk_pt();
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge sys_clk);
    reg_we    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_we <= 1'b0;
  endtask : wr

  // read data stands in the cycle after the strobe only
  task automatic rdchk(input logic [3:0] a, input logic [15:0] m, e,
                       input string s);
    @(posedge sys_clk);
    reg_re   <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_re <= 1'b0;
    @(negedge sys_clk);
    rv = reg_rdata;
    chk(rv & m, e, s);
    @(negedge sys_clk);
    chk(reg_rdata, 16'h0000, "read data held");
  endtask : rdchk

  task automatic cfg(input logic [15:0] c, t, d, i);
    wr(4'h0, c);
    wr(4'h1, t);
    wr(4'h2, d);
    wr(4'h3, i);
    foreach (acc[k])
      acc[k] = 0;
  endtask : cfg

  task automatic trig();
    @(posedge sys_clk);
    fire <= 1'b1;
    @(posedge sys_clk);
    fire <= 1'b0;
    repeat (3) @(posedge sys_clk);
  endtask : trig

  // a slow source leaves idle cycles between samples
  task automatic put(input int s);
    if (slow && s[3]) begin
      @(posedge sys_clk);
      feed <= 1'b0;
    end
    @(posedge sys_clk);
    feed      <= 1'b1;
    feed_data <= s[7:0];
  endtask : put

  // n intervals of dec samples; expected points kept when show is set
  task automatic stream(input int n, dec, pk, show, sh);
    int i, j, s, f, h, l;
    for (i = 0; i < n; i++) begin
      h = 0;
      l = 255;
      f = 0;
      for (j = 0; j < dec; j++) begin
        s = rnd() & 255;
        if (j == 0) f = s;
        if (s > h) h = s;
        if (s < l) l = s;
        put(s);
      end
      acc[i] = (sh == 0) ? f : acc[i] + f;
      if (show) begin
        q_a.push_back(i);
        q_h.push_back(pk ? h : acc[i] >> sh);
        q_l.push_back(pk ? l : acc[i] >> sh);
      end
    end
    @(posedge sys_clk);
    feed <= 1'b0;
  endtask : stream

  // bounded wait for the next record end
  task automatic wait_rec();
    int k;
    nr++;
    for (k = 0; k < 400 && n_rec < nr; k++)
      @(posedge sys_clk);
    chk(16'(n_rec), 16'(nr), "record count");
    chk(16'(q_a.size()), 16'h0000, "points missing");
  endtask : wait_rec

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    #900000;
    n_fail++;
    $display("CHECK FAILED %0t run hung", $time);
    test_done();
  end

  // main sequence
  initial begin
    int k;
    repeat (4) @(posedge sys_clk);
    nrst <= 1'b1;
    for (k = 0; k < 16; k++)
      rdchk(4'(k), 16'hFFFF, (k == 2) ? 16'h0001 : 16'h0000, "reset val");
    cfg(16'h0001, 16'h0011, 16'h0002, 16'h0000);
    rdchk(4'h5, 16'h0020, 16'h0000, "peak forced off");
    wr(4'h4, 16'h0002);
    trig();
    stream(2500, 2, 0, 1, 0);
    wait_rec();
    rdchk(4'h5, 16'h000F, 16'h0000, "halt after one");
    cfg(16'h0001, 16'h0012, 16'h0002, 16'h0000);
    rdchk(4'h5, 16'h0020, 16'h0020, "peak on");
    slow = 1;
    wr(4'h4, 16'h0002);
    trig();
    stream(1250, 2, 1, 1, 0);
    slow = 0;
    wait_rec();
    cfg(16'h0002, 16'h0005, 16'h0001, 16'h0000);
    wr(4'h4, 16'h0002);
    for (k = 0; k < 4; k++) begin
      trig();
      stream(2500, 1, 0, k == 3, 2);
      wait_rec();
      if (k == 0)
        rdchk(4'h5, 16'hFE04, 16'h0204, "one averaged");
    end
    rdchk(4'h5, 16'h000F, 16'h0000, "avg done");
    for (k = 0; k < 4; k++) begin
      wr(4'h0, 16'(2 + 4 * k));
      rdchk(4'h0, 16'h001F, 16'(2 + 4 * k), "count field");
    end
    cfg(16'h0000, 16'h0005, 16'h0001, 16'h0000);
    wr(4'h4, 16'h0001);
    @(negedge sys_clk);
    chk(16'(acq_running), 16'h0001, "running");
    for (k = 0; k < 2; k++) begin
      trig();
      stream(2500, 1, 0, 1, 0);
      wait_rec();
      rdchk(4'h5, 16'h0005, 16'h0005, "re-armed");
    end
    wr(4'h4, 16'h0001);
    @(negedge sys_clk);
    chk(16'(acq_running), 16'h0000, "halted");
    stream(60, 1, 0, 0, 0);
    // spare mode code acts as sample, a zero divisor as one
    cfg(16'h0003, 16'h0005, 16'h0000, 16'h0000);
    wr(4'h4, 16'h0001);
    trig();
    stream(100, 1, 0, 1, 0);
    repeat (8) @(posedge sys_clk);
    wr(4'h1, 16'h0005);
    rdchk(4'h6, 16'h0FFF, 16'h0000, "index restart");
    rdchk(4'h5, 16'h000C, 16'h0004, "back to armed");
    wr(4'h4, 16'h0001);
    cfg(16'h0010, 16'h0016, 16'h0001, 16'h0000);
    wr(4'h4, 16'h0001);
    rdchk(4'h5, 16'h0010, 16'h0010, "rolling on");
    roll = 1;
    stream(300, 1, 0, 1, 0);
    repeat (8) @(posedge sys_clk);
    chk(16'(q_a.size()), 16'h0000, "roll points");
    roll = 0;
    wr(4'h0, 16'h0000);
    rdchk(4'h5, 16'h0010, 16'h0000, "rolling off");
    wr(4'h4, 16'h0001);
    cfg(16'h0000, 16'h0004, 16'h0001, 16'h0001);
    // both command bits at once: the one-shot wins
    wr(4'h4, 16'h0003);
    trig();
    loose = 1;
    for (k = 0; k < 8000 && n_rec <= nr; k++)
      put(rnd());
    @(posedge sys_clk);
    feed <= 1'b0;
    wait_rec();
    chk(16'(n_loose), 16'd2500, "filled points");
    rdchk(4'h5, 16'h000F, 16'h0000, "one-shot wins");
    loose = 0;
    test_done();
  end
endmodule : test_waveform_acquisition_control
`default_nettype wire
